/* core/dp_host_defs.vh */
`ifndef DP_HOST_DEFS_VH
`define DP_HOST_DEFS_VH

// Register byte offsets on the APB port
`define ADDR_CTRL 8'h00
`define ADDR_STROBE 8'h04
`define ADDR_STATUS 8'h08
`define ADDR_INT_STAT 8'h0C
`define ADDR_INT_MASK 8'h10

// Control register: each bit is the level driven on one device pin
`define CTRL_W 21
`define B_MEM_DIR_N 0
`define B_SBE_LO_N 1
`define B_SBE_HI_N 2
`define B_CPU_GATE 3
`define B_CPU_SEL_N 4
`define B_MEM_GATE 5
`define B_MEM_SEL_N 6
`define B_SDIR_LO_N 7
`define B_SDIR_HI_N 8
`define B_SEN_LO_N 9
`define B_SEN_HI_N 10
`define B_LOBUF_SEL 11
`define B_SLOT_SEL_N 12
`define B_SWAP_DIR 13
`define B_SWAP_EN_N 14
`define B_PDIR_N 15
`define B_PEN_N 16
`define B_BE_LO_N 17
`define B_BE_HI_N 18
`define B_CAS_A_N 19
`define B_CAS_B_N 20

// Reset value: every driver enable, byte enable and column strobe negated
`define CTRL_RESET 21'h1FD7D7
// Output enables (active low) and direction bits
`define EN_MASK 21'h014606
`define DIR_MASK 21'h00A181

// Strobe register bits
`define S_CONV 0
`define S_SLOT 1

// Status and interrupt bits
`define ST_BUSY 0
`define ST_PERR_N 1
`define INT_PERR 0
`define INT_DONE 1
`define INT_REFUSED 2
`define INT_W 3

// Timing counts in SYS_CLK cycles
`define STROBE_CYCLES 2
`define TURN_CYCLES 1

`endif

/* core/dp_sync2.v */
`default_nettype none

// Two-stage synchroniser for levels arriving from the data path device
module dp_sync2 #(
	parameter WIDTH = 1
) (
	// Clock and reset
	input wire clk,
	input wire reset_n,
	// Data
	input wire [WIDTH-1:0] d,
	output reg [WIDTH-1:0] q
);

	reg [WIDTH-1:0] meta_reg;

	// First stage feeds only the second stage
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_reg <= {WIDTH{1'b1}};
			q <= {WIDTH{1'b1}};
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end

endmodule // dp_sync2

`default_nettype wire

/* core/dp_host.v */
// Contract
// - Memory direction low moves memory bytes to processor; high moves processor bytes to memory.
// - Low system/processor byte: direction low routes system to processor; enable low drives.
// - High system/processor byte: direction low routes system to processor; enable low drives.
// - Swap enabled: direction high copies low byte to high, low copies high to low.
// - Peripheral buffer: direction low moves peripheral to system; drives while enable low.
// - A 32-bit path uses two 16-bit data path devices, one per half.
// - Buffer select high routes latched system low byte to processor; low routes live.
`default_nettype none
`include "dp_host_defs.vh"

module dp_host #(
	parameter STROBE_CYCLES = `STROBE_CYCLES,
	parameter TURN_CYCLES = `TURN_CYCLES
) (
	// Clock and reset
	input wire SYS_CLK,
	input wire RESET_N,
	// APB slave
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [7:0] PADDR,
	input wire [31:0] PWDATA,
	output reg [31:0] PRDATA,
	output reg PREADY,
	output reg PSLVERR,
	output reg IRQ,
	// Data path control pins driven to one 16-bit device; a 32-bit path pairs two controllers
	output wire MEMORY_READ_DIR_N,
	output wire SYS_BYTE_EN_LO_N,
	output wire SYS_BYTE_EN_HI_N,
	output wire CPU_LATCH_GATE,
	output wire CPU_LATCHED_SELECT_N,
	output wire MEM_LATCH_GATE,
	output wire MEM_LATCHED_SELECT_N,
	output wire SYS_TO_CPU_DIR_LO_N,
	output wire SYS_TO_CPU_DIR_HI_N,
	output wire SYS_CPU_EN_LO_N,
	output wire SYS_CPU_EN_HI_N,
	output wire LOW_BUFFER_LATCHED_SELECT,
	output wire SLOT_HIGH_LIVE_SELECT_N,
	output wire SWAP_DIRECTION,
	output wire SWAP_ENABLE_N,
	output wire PERIPH_READ_DIR_N,
	output wire PERIPH_BUFFER_EN_N,
	output wire CPU_BYTE_EN_LO_N,
	output wire CPU_BYTE_EN_HI_N,
	output wire BANK_A_COL_STROBE_IN_N,
	output wire BANK_B_COL_STROBE_IN_N,
	// Latch strobes driven to the device
	output reg CONVERSION_STROBE,
	output reg SLOT_HIGH_LATCH_STROBE,
	// Device outputs observed
	input wire PARITY_ERROR_OUT_N,
	input wire LATCHED_BYTE_EN_LO_N,
	input wire LATCHED_BYTE_EN_HI_N,
	input wire BANK_A_LO_COL_STROBE_N,
	input wire BANK_A_HI_COL_STROBE_N,
	input wire BANK_B_LO_COL_STROBE_N,
	input wire BANK_B_HI_COL_STROBE_N
);

	localparam ST_IDLE = 2'd0;
	localparam ST_OFF = 2'd1;
	localparam ST_TURN = 2'd2;

	// True when two drivers would fight on one system data byte
	function bus_conflict;
		input [`CTRL_W-1:0] c;
		reg lo_a, lo_b, lo_c, hi_a, hi_b;
		begin
			lo_a = !c[`B_PEN_N] && !c[`B_PDIR_N];
			lo_b = !c[`B_SEN_LO_N] && c[`B_SDIR_LO_N];
			lo_c = !c[`B_SWAP_EN_N] && !c[`B_SWAP_DIR];
			hi_a = !c[`B_SEN_HI_N] && c[`B_SDIR_HI_N];
			hi_b = !c[`B_SWAP_EN_N] && c[`B_SWAP_DIR];
			bus_conflict = (lo_a && lo_b) || (lo_a && lo_c) || (lo_b && lo_c) || (hi_a && hi_b);
		end
	endfunction

	// Register decode, shared by read and write paths
	function [2:0] reg_sel;
		input [7:0] a;
		begin
			case (a)
				`ADDR_CTRL: reg_sel = 3'h1;
				`ADDR_STROBE: reg_sel = 3'h2;
				`ADDR_STATUS: reg_sel = 3'h3;
				`ADDR_INT_STAT: reg_sel = 3'h4;
				`ADDR_INT_MASK: reg_sel = 3'h5;
				default: reg_sel = 3'h0;
			endcase
		end
	endfunction

	reg [`CTRL_W-1:0] ctrl_reg;
	reg [`CTRL_W-1:0] pins_reg;
	reg [1:0] state_reg;
	reg [7:0] turn_cnt_reg;
	reg [`INT_W-1:0] int_stat_reg;
	reg [`INT_W-1:0] int_mask_reg;
	reg perr_seen_reg;
	reg [1:0] strobe_go;
	wire [6:0] dev_sync;
	wire [2:0] sel;
	wire access;
	wire done_xfer;
	wire wr_ctrl;
	wire refuse;
	wire perr_now;
	reg [`INT_W-1:0] int_set;
	reg [31:0] rd_data;

	// Device outputs come from another chip, so they pass two flops
	dp_sync2 #(.WIDTH(7)) u_sync (
		.clk(SYS_CLK),
		.reset_n(RESET_N),
		.d({BANK_B_HI_COL_STROBE_N, BANK_B_LO_COL_STROBE_N, BANK_A_HI_COL_STROBE_N,
			BANK_A_LO_COL_STROBE_N, LATCHED_BYTE_EN_HI_N, LATCHED_BYTE_EN_LO_N, PARITY_ERROR_OUT_N}),
		.q(dev_sync)
	);

	// Pin levels straight from the pin register
	assign MEMORY_READ_DIR_N = pins_reg[`B_MEM_DIR_N];
	assign SYS_BYTE_EN_LO_N = pins_reg[`B_SBE_LO_N];
	assign SYS_BYTE_EN_HI_N = pins_reg[`B_SBE_HI_N];
	assign CPU_LATCH_GATE = pins_reg[`B_CPU_GATE];
	assign CPU_LATCHED_SELECT_N = pins_reg[`B_CPU_SEL_N];
	assign MEM_LATCH_GATE = pins_reg[`B_MEM_GATE];
	assign MEM_LATCHED_SELECT_N = pins_reg[`B_MEM_SEL_N];
	assign SYS_TO_CPU_DIR_LO_N = pins_reg[`B_SDIR_LO_N];
	assign SYS_TO_CPU_DIR_HI_N = pins_reg[`B_SDIR_HI_N];
	assign SYS_CPU_EN_LO_N = pins_reg[`B_SEN_LO_N];
	assign SYS_CPU_EN_HI_N = pins_reg[`B_SEN_HI_N];
	assign LOW_BUFFER_LATCHED_SELECT = pins_reg[`B_LOBUF_SEL];
	assign SLOT_HIGH_LIVE_SELECT_N = pins_reg[`B_SLOT_SEL_N];
	assign SWAP_DIRECTION = pins_reg[`B_SWAP_DIR];
	assign SWAP_ENABLE_N = pins_reg[`B_SWAP_EN_N];
	assign PERIPH_READ_DIR_N = pins_reg[`B_PDIR_N];
	assign PERIPH_BUFFER_EN_N = pins_reg[`B_PEN_N];
	assign CPU_BYTE_EN_LO_N = pins_reg[`B_BE_LO_N];
	assign CPU_BYTE_EN_HI_N = pins_reg[`B_BE_HI_N];
	assign BANK_A_COL_STROBE_IN_N = pins_reg[`B_CAS_A_N];
	assign BANK_B_COL_STROBE_IN_N = pins_reg[`B_CAS_B_N];

	// Bus handshake: one wait state, completion at the edge PREADY is high
	assign sel = reg_sel(PADDR);
	assign access = PSEL && PENABLE;
	assign done_xfer = access && PREADY;
	// Control writes that would fight on the bus, or arrive mid-turnaround, are refused
	assign refuse = PWRITE && (sel == 3'h1) && ((state_reg != ST_IDLE) || bus_conflict(PWDATA[`CTRL_W-1:0]));
	assign wr_ctrl = done_xfer && PWRITE && (sel == 3'h1) && !refuse;
	// Error output counts only while the device is set for a read
	assign perr_now = !dev_sync[0] && !pins_reg[`B_MEM_DIR_N];

	// Read mux
	always @* begin
		rd_data = 32'h0000_0000;
		case (sel)
			3'h1: rd_data[`CTRL_W-1:0] = ctrl_reg;
			3'h3: rd_data[7:0] = {dev_sync, state_reg != ST_IDLE};
			3'h4: rd_data[`INT_W-1:0] = int_stat_reg;
			3'h5: rd_data[`INT_W-1:0] = int_mask_reg;
			default: rd_data = 32'h0000_0000;
		endcase
	end

	// Interrupt events of this cycle
	always @* begin
		int_set = {`INT_W{1'b0}};
		int_set[`INT_PERR] = perr_now && !perr_seen_reg;
		int_set[`INT_DONE] = (state_reg == ST_TURN) && (turn_cnt_reg == 8'h00);
		int_set[`INT_REFUSED] = done_xfer && refuse;
	end

	// APB answer, interrupt status and mask
	always @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			PREADY <= 1'b0;
			PRDATA <= 32'h0000_0000;
			PSLVERR <= 1'b0;
			IRQ <= 1'b0;
			int_stat_reg <= {`INT_W{1'b0}};
			int_mask_reg <= {`INT_W{1'b0}};
			perr_seen_reg <= 1'b0;
		end else begin
			PREADY <= access && !PREADY;
			PRDATA <= (access && !PREADY && !PWRITE) ? rd_data : 32'h0000_0000;
			PSLVERR <= access && !PREADY && ((sel == 3'h0) || refuse || (sel == 3'h3 && PWRITE));
			perr_seen_reg <= perr_now;
			// A new event wins over the clear by read
			if (done_xfer && !PWRITE && sel == 3'h4) begin
				int_stat_reg <= int_set;
			end else begin
				int_stat_reg <= int_stat_reg | int_set;
			end
			if (done_xfer && PWRITE && sel == 3'h5) begin
				int_mask_reg <= PWDATA[`INT_W-1:0];
			end
			IRQ <= |((int_stat_reg | int_set) & int_mask_reg);
		end
	end

	// Pin sequencer: on a direction change, enables go off, directions turn, enables return
	always @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ctrl_reg <= `CTRL_RESET;
			pins_reg <= `CTRL_RESET;
			state_reg <= ST_IDLE;
			turn_cnt_reg <= 8'h00;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (wr_ctrl) begin
						ctrl_reg <= PWDATA[`CTRL_W-1:0];
						if (|((PWDATA[`CTRL_W-1:0] ^ pins_reg) & `DIR_MASK)) begin
							pins_reg <= pins_reg | `EN_MASK;
							turn_cnt_reg <= TURN_CYCLES[7:0] - 8'h01;
							state_reg <= ST_OFF;
						end else begin
							pins_reg <= PWDATA[`CTRL_W-1:0];
						end
					end
				end
				ST_OFF: begin
					if (turn_cnt_reg == 8'h00) begin
						pins_reg <= ctrl_reg | `EN_MASK;
						turn_cnt_reg <= TURN_CYCLES[7:0] - 8'h01;
						state_reg <= ST_TURN;
					end else begin
						turn_cnt_reg <= turn_cnt_reg - 8'h01;
					end
				end
				ST_TURN: begin
					if (turn_cnt_reg == 8'h00) begin
						pins_reg <= ctrl_reg;
						state_reg <= ST_IDLE;
					end else begin
						turn_cnt_reg <= turn_cnt_reg - 8'h01;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// Strobe register write launches a fixed-width high pulse per bit
	always @* begin
		strobe_go = 2'b00;
		if (done_xfer && PWRITE && sel == 3'h2) begin
			strobe_go = PWDATA[1:0];
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_strobe
			reg [7:0] cnt_reg;
			// A restart while running only stretches the pulse, no extra edge
			always @(posedge SYS_CLK or negedge RESET_N) begin
				if (!RESET_N) begin
					cnt_reg <= 8'h00;
				end else if (strobe_go[gi]) begin
					cnt_reg <= STROBE_CYCLES[7:0];
				end else if (cnt_reg != 8'h00) begin
					cnt_reg <= cnt_reg - 8'h01;
				end
			end
		end
	endgenerate

	// Strobe pins from flops; rising edge makes the device capture
	always @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			CONVERSION_STROBE <= 1'b0;
			SLOT_HIGH_LATCH_STROBE <= 1'b0;
		end else begin
			CONVERSION_STROBE <= strobe_go[`S_CONV] || (g_strobe[0].cnt_reg > 8'h01);
			SLOT_HIGH_LATCH_STROBE <= strobe_go[`S_SLOT] || (g_strobe[1].cnt_reg > 8'h01);
		end
	end

endmodule // dp_host

`default_nettype wire

/* testbench/dp_device_model.sv */
`default_nettype none
// Data path device: byte enable latch, column strobe split and parity check
module dp_device_model (
	// Controls from the controller
	input wire logic gate,
	input wire logic sel_n,
	input wire logic mem_dir_n,
	input wire logic [1:0] sbe_n,
	input wire logic [1:0] be_n,
	input wire logic cas_a_n,
	input wire logic cas_b_n,
	// Memory bus, driven by the bench
	input wire logic [15:0] md,
	input wire logic [1:0] pty,
	// Back to the controller
	output logic perr_n,
	output logic [1:0] lbe_n,
	output logic [3:0] cas_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] be_q = 2'h3;
	// Enables captured on the rising gate edge
	always @(posedge gate) be_q <= be_n;
	// One byte select feeds both the latched enables and the strobe split
	assign lbe_n = sel_n ? sbe_n : be_q;
	assign cas_n = {cas_b_n | lbe_n[1], cas_b_n | lbe_n[0], cas_a_n | lbe_n[1], cas_a_n | lbe_n[0]};
	// Odd weight is an error; the direction term blocks it on writes
	assign perr_n = mem_dir_n | ~((^{md[7:0], pty[0]} & ~be_n[0]) | (^{md[15:8], pty[1]} & ~be_n[1]));
endmodule // dp_device_model
`default_nettype wire

/* testbench/dp_host_sva.sv */
`default_nettype none
// Watches the controller's bus answer and the pins it drives
module dp_host_sva #(
	parameter STROBE_CYCLES = 2
) (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RESET_N,
	// APB
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	// Device pins
	input wire logic MEMORY_READ_DIR_N,
	input wire logic SYS_BYTE_EN_LO_N,
	input wire logic SYS_BYTE_EN_HI_N,
	input wire logic SYS_TO_CPU_DIR_LO_N,
	input wire logic SYS_TO_CPU_DIR_HI_N,
	input wire logic SYS_CPU_EN_LO_N,
	input wire logic SYS_CPU_EN_HI_N,
	input wire logic SWAP_DIRECTION,
	input wire logic SWAP_ENABLE_N,
	input wire logic PERIPH_READ_DIR_N,
	input wire logic PERIPH_BUFFER_EN_N,
	input wire logic CONVERSION_STROBE,
	input wire logic SLOT_HIGH_LATCH_STROBE
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] conv_cnt;
	wire [5:0] en_n = {SYS_BYTE_EN_LO_N, SYS_BYTE_EN_HI_N, SYS_CPU_EN_LO_N, SYS_CPU_EN_HI_N, SWAP_ENABLE_N, PERIPH_BUFFER_EN_N};
	wire [4:0] dirs = {MEMORY_READ_DIR_N, SYS_TO_CPU_DIR_LO_N, SYS_TO_CPU_DIR_HI_N, SWAP_DIRECTION, PERIPH_READ_DIR_N};
	wire wr_strobe = PSEL && PENABLE && PREADY && PWRITE && PADDR == 8'h04;
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RESET_N);
	// Counts high cycles of the conversion pulse
	always @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			conv_cnt <= 4'h0;
		end else begin
			conv_cnt <= CONVERSION_STROBE ? conv_cnt + 4'h1 : 4'h0;
		end
	end
	AST_PREADY_ONE_WAIT: assert property ((PSEL && !PENABLE) ##1 (PSEL && PENABLE) |-> !PREADY ##1 PREADY)
		else $error("pready not after one wait state");
	AST_UNMAPPED: assert property (PSEL && PENABLE && PREADY && PADDR > 8'h10 |-> PSLVERR && (PWRITE || PRDATA == 32'h0))
		else $error("unmapped access not refused");
	AST_TURN_DRIVERS_OFF: assert property ($changed(dirs) |-> &en_n && &$past(en_n))
		else $error("direction changed with a driver on");
	AST_SD_LO_ONE_DRIVER: assert property ($onehot0({!PERIPH_BUFFER_EN_N && !PERIPH_READ_DIR_N,
		!SYS_CPU_EN_LO_N && SYS_TO_CPU_DIR_LO_N, !SWAP_ENABLE_N && !SWAP_DIRECTION}))
		else $error("two drivers on system low byte");
	AST_SD_HI_ONE_DRIVER: assert property ($onehot0({!SYS_CPU_EN_HI_N && SYS_TO_CPU_DIR_HI_N,
		!SWAP_ENABLE_N && SWAP_DIRECTION}))
		else $error("two drivers on system high byte");
	AST_CONV_START: assert property (wr_strobe && PWDATA[0] |=> $rose(CONVERSION_STROBE))
		else $error("conversion pulse did not start");
	AST_CONV_WIDTH: assert property ($fell(CONVERSION_STROBE) |-> conv_cnt == STROBE_CYCLES)
		else $error("conversion pulse width wrong");
	AST_SLOT_START: assert property (wr_strobe && PWDATA[1] |=> $rose(SLOT_HIGH_LATCH_STROBE))
		else $error("slot pulse did not start");
endmodule // dp_host_sva
bind dp_host dp_host_sva #(.STROBE_CYCLES(STROBE_CYCLES)) i_dp_host_sva (.*);
`default_nettype wire

/* testbench/tb_top.sv */
`default_nettype none
`include "dp_host_defs.vh"
// Drives the controller over APB against a model of the data path device
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] CR = {11'h000, `CTRL_RESET};
	localparam logic [31:0] RDC = CR & ~32'h000E0007;
	logic SYS_CLK = 1'b0, RESET_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, err;
	logic [7:0] PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0, rd;
	logic [15:0] md = 16'h0000;
	logic [1:0] pty = 2'h0;
	wire [31:0] PRDATA;
	wire PREADY, PSLVERR, IRQ, CONVERSION_STROBE, SLOT_HIGH_LATCH_STROBE, PARITY_ERROR_OUT_N;
	wire MEMORY_READ_DIR_N, SYS_BYTE_EN_LO_N, SYS_BYTE_EN_HI_N, CPU_LATCH_GATE, CPU_LATCHED_SELECT_N;
	wire MEM_LATCH_GATE, MEM_LATCHED_SELECT_N, SYS_TO_CPU_DIR_LO_N, SYS_TO_CPU_DIR_HI_N, SYS_CPU_EN_LO_N;
	wire SYS_CPU_EN_HI_N, LOW_BUFFER_LATCHED_SELECT, SLOT_HIGH_LIVE_SELECT_N, SWAP_DIRECTION, SWAP_ENABLE_N;
	wire PERIPH_READ_DIR_N, PERIPH_BUFFER_EN_N, CPU_BYTE_EN_LO_N, CPU_BYTE_EN_HI_N;
	wire BANK_A_COL_STROBE_IN_N, BANK_B_COL_STROBE_IN_N, LATCHED_BYTE_EN_LO_N, LATCHED_BYTE_EN_HI_N;
	wire BANK_A_LO_COL_STROBE_N, BANK_A_HI_COL_STROBE_N, BANK_B_LO_COL_STROBE_N, BANK_B_HI_COL_STROBE_N;
	// All control pins in control register bit order, so every pin is compared as one word
	wire [31:0] pins = {11'h000, BANK_B_COL_STROBE_IN_N, BANK_A_COL_STROBE_IN_N,
		CPU_BYTE_EN_HI_N, CPU_BYTE_EN_LO_N, PERIPH_BUFFER_EN_N, PERIPH_READ_DIR_N,
		SWAP_ENABLE_N, SWAP_DIRECTION, SLOT_HIGH_LIVE_SELECT_N, LOW_BUFFER_LATCHED_SELECT,
		SYS_CPU_EN_HI_N, SYS_CPU_EN_LO_N, SYS_TO_CPU_DIR_HI_N, SYS_TO_CPU_DIR_LO_N,
		MEM_LATCHED_SELECT_N, MEM_LATCH_GATE, CPU_LATCHED_SELECT_N, CPU_LATCH_GATE,
		SYS_BYTE_EN_HI_N, SYS_BYTE_EN_LO_N, MEMORY_READ_DIR_N};
	int num_errors = 0, checks_done = 0;
	dp_host #(.STROBE_CYCLES(2), .TURN_CYCLES(1)) i_dp_host (.*);
	dp_device_model i_dp_device_model (.gate(CPU_LATCH_GATE), .sel_n(CPU_LATCHED_SELECT_N),
		.mem_dir_n(MEMORY_READ_DIR_N), .sbe_n({SYS_BYTE_EN_HI_N, SYS_BYTE_EN_LO_N}),
		.be_n({CPU_BYTE_EN_HI_N, CPU_BYTE_EN_LO_N}), .cas_a_n(BANK_A_COL_STROBE_IN_N),
		.cas_b_n(BANK_B_COL_STROBE_IN_N), .md(md), .pty(pty), .perr_n(PARITY_ERROR_OUT_N),
		.lbe_n({LATCHED_BYTE_EN_HI_N, LATCHED_BYTE_EN_LO_N}), .cas_n({BANK_B_HI_COL_STROBE_N,
		BANK_B_LO_COL_STROBE_N, BANK_A_HI_COL_STROBE_N, BANK_A_LO_COL_STROBE_N}));
	// Free-running 40 MHz clock
	initial forever #12.5 SYS_CLK = ~SYS_CLK;
	// One APB transfer, entered just after an edge; idles one cycle so strobes never toggle twice
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
		int n;
		n = 0;
		PSEL <= 1'b1;
		PWRITE <= wr;
		PADDR <= addr;
		PWDATA <= wdata;
		@(posedge SYS_CLK);
		PENABLE <= 1'b1;
		do begin
			@(posedge SYS_CLK);
			n++;
		end while (PREADY !== 1'b1 && n < 20);
		if (n >= 20) num_errors++;
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge SYS_CLK);
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic rchk(input string what, input logic [7:0] addr, input logic [31:0] exp);
		apb(1'b0, addr, 32'h0);
		chk(what, exp, rd);
	endtask
	task automatic wchk(input logic [7:0] addr, input logic [31:0] data, input logic exp_err);
		apb(1'b1, addr, data);
		chk("slverr", {31'h0, exp_err}, {31'h0, err});
	endtask
	task automatic finish_test();
		$display("checks %0d, mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Hang guard, well beyond the roughly 150 cycles the tests need
	initial begin
		#75000;
		num_errors++;
		finish_test();
	end
	initial begin
		repeat (12) @(posedge SYS_CLK);
		RESET_N <= 1'b1;
		@(posedge SYS_CLK);
		rchk("ctrl", `ADDR_CTRL, CR);
		chk("pins", CR, pins);
		rchk("status", `ADDR_STATUS, 32'hFE);
		rchk("unmapped", 8'h14, 32'h0);
		$display("test reset done");
		wchk(`ADDR_CTRL, RDC, 1'b0);
		repeat (6) @(posedge SYS_CLK);
		chk("dir", 32'h0, {31'h0, MEMORY_READ_DIR_N});
		chk("pins", RDC, pins);
		rchk("int", `ADDR_INT_STAT, 32'h2);
		rchk("status", `ADDR_STATUS, 32'hC2);
		$display("test turn done");
		wchk(`ADDR_INT_MASK, 32'h1, 1'b0);
		md <= 16'h0100;
		repeat (6) @(posedge SYS_CLK);
		chk("irq", 32'h1, {31'h0, IRQ});
		rchk("status", `ADDR_STATUS, 32'hC0);
		rchk("int", `ADDR_INT_STAT, 32'h1);
		@(posedge SYS_CLK);
		chk("irq", 32'h0, {31'h0, IRQ});
		wchk(`ADDR_INT_MASK, 32'h0, 1'b0);
		md <= 16'h0000;
		repeat (6) @(posedge SYS_CLK);
		md <= 16'h0001;
		repeat (6) @(posedge SYS_CLK);
		chk("irq", 32'h0, {31'h0, IRQ});
		rchk("int", `ADDR_INT_STAT, 32'h1);
		md <= 16'h0000;
		$display("test parity done");
		wchk(`ADDR_CTRL, RDC & ~32'h00018200, 1'b1);
		rchk("ctrl", `ADDR_CTRL, RDC);
		chk("pins", RDC, pins);
		wchk(`ADDR_STATUS, 32'h0, 1'b1);
		rchk("int", `ADDR_INT_STAT, 32'h4);
		$display("test refuse done");
		// Byte enables settle a write before the gate rises, as the edge latch needs setup
		wchk(`ADDR_CTRL, RDC | 32'h00020000, 1'b0);
		wchk(`ADDR_CTRL, RDC | 32'h00020008, 1'b0);
		wchk(`ADDR_CTRL, RDC & ~32'h10, 1'b0);
		repeat (6) @(posedge SYS_CLK);
		rchk("status", `ADDR_STATUS, 32'hD6);
		chk("pins", RDC & ~32'h10, pins);
		$display("test latch done");
		wchk(`ADDR_STROBE, 32'h3, 1'b0);
		chk("conv", 32'h1, {31'h0, CONVERSION_STROBE});
		chk("slot", 32'h1, {31'h0, SLOT_HIGH_LATCH_STROBE});
		@(posedge SYS_CLK);
		chk("conv", 32'h1, {31'h0, CONVERSION_STROBE});
		chk("slot", 32'h1, {31'h0, SLOT_HIGH_LATCH_STROBE});
		@(posedge SYS_CLK);
		chk("conv", 32'h0, {31'h0, CONVERSION_STROBE});
		chk("slot", 32'h0, {31'h0, SLOT_HIGH_LATCH_STROBE});
		$display("test strobe done");
		wchk(`ADDR_CTRL, CR, 1'b0);
		chk("pins", (RDC & ~32'h10) | `EN_MASK, pins);
		repeat (6) @(posedge SYS_CLK);
		md <= 16'h0100;
		repeat (6) @(posedge SYS_CLK);
		rchk("status", `ADDR_STATUS, 32'hFE);
		chk("pins", CR, pins);
		rchk("int", `ADDR_INT_STAT, 32'h2);
		$display("test write done");
		finish_test();
	end
endmodule // tb_top
`default_nettype wire
